/* File: esm_regs.vh */
// register offsets, field positions, reset values and timing counts
// for the emergency stop monitor; included by the monitor design file only
`ifndef ESM_REGS_VH
`define ESM_REGS_VH

// register offsets (byte addresses, one aligned word each)
`define ESM_ADDR_CTRL      8'h00
`define ESM_ADDR_STATUS    8'h04
`define ESM_ADDR_IRQ_STAT  8'h08
`define ESM_ADDR_IRQ_MASK  8'h0c

// control register fields
`define ESM_CTRL_ACTIVATE  0
`define ESM_CTRL_STARTUP   1
`define ESM_CTRL_RELEASE   2
`define ESM_CTRL_RESET     3'h0

// status register fields
`define ESM_STAT_READY     16
`define ESM_STAT_ENABLE    17
`define ESM_STAT_ERROR     18
`define ESM_STAT_STOP      19
`define ESM_STAT_RESET     20

// interrupt status and mask fields
`define ESM_IRQ_ERROR      0
`define ESM_IRQ_DROP       1
`define ESM_IRQ_RAISE      2
`define ESM_IRQ_RESET      3'h0

// diagnostic codes per state
`define ESM_CODE_IDLE      16'h0000
`define ESM_CODE_INIT      16'h8001
`define ESM_CODE_WAIT_REQ1 16'h8002
`define ESM_CODE_WAIT_RST1 16'h8003
`define ESM_CODE_ENABLE    16'h8000
`define ESM_CODE_WAIT_REQ2 16'h8004
`define ESM_CODE_WAIT_RST2 16'h8005
`define ESM_CODE_RST_ERR1  16'hc001
`define ESM_CODE_RST_ERR2  16'hc002

// execution cycle timing
`define ESM_CLK_PERIOD_NS  8
`define ESM_EXEC_CYCLE_NS  1000
`define ESM_EXEC_DIV \
  ((`ESM_EXEC_CYCLE_NS + `ESM_CLK_PERIOD_NS - 1) / `ESM_CLK_PERIOD_NS)

`endif

/* File: esm_sync2.v */
// two flip-flop synchroniser for a group of pin inputs
// assumes the inputs are asynchronous levels, not pulses
`timescale 1ns/10ps
module esm_sync2 #(
  parameter W = 2
) (
  // clock and reset
  input  wire         sys_clk,
  input  wire         rst_n,
  // levels
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  // first stage feeds only the second
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule // esm_sync2

/* File: esm_cycle_tick.v */
// execution cycle divider: one-cycle tick every DIV clocks
// assumes DIV is at least 1
`timescale 1ns/10ps
module esm_cycle_tick #(
  parameter        DIV = 125
) (
  // clock and reset
  input  wire      sys_clk,
  input  wire      rst_n,
  // execution cycle pulse
  output wire      tick
);

  reg  [15:0] cnt_reg;
  wire        wrap;

  assign wrap = (cnt_reg == DIV[15:0] - 16'h0001);

  // free-running count, wraps at DIV
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 16'h0000;
    end else if (wrap) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  assign tick = wrap;

endmodule // esm_cycle_tick

/* File: esm_emergency_stop_monitor.v */
// emergency stop monitor: safety state machine with register port
// assumes stop and confirm-reset pins are asynchronous to sys_clk and
// that software sets activate and the confirm options via ctrl.
`timescale 1ns/10ps
`include "esm_regs.vh"
module esm_emergency_stop_monitor #(
  parameter EXEC_DIV = `ESM_EXEC_DIV
) (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  // register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output wire [31:0] reg_rdata,
  // emergency stop button and operator reset pins
  input  wire        stop_request_in,
  input  wire        confirm_reset_in,
  // safety outputs
  output wire        safety_enable_out,
  output wire        ready_out,
  output wire        error_out,
  output wire [15:0] diagnostic_code,
  // interrupt
  output wire        irq_out
);

  // one-hot states
  localparam [8:0] ST_IDLE      = 9'h001;
  localparam [8:0] ST_INIT      = 9'h002;
  localparam [8:0] ST_WAIT_REQ1 = 9'h004;
  localparam [8:0] ST_WAIT_RST1 = 9'h008;
  localparam [8:0] ST_ENABLE    = 9'h010;
  localparam [8:0] ST_WAIT_REQ2 = 9'h020;
  localparam [8:0] ST_WAIT_RST2 = 9'h040;
  localparam [8:0] ST_RST_ERR1  = 9'h080;
  localparam [8:0] ST_RST_ERR2  = 9'h100;

  // diagnostic code of a state
  function [15:0] state_code;
    input [8:0] st;
    begin
      case (st)
        ST_INIT:      state_code = `ESM_CODE_INIT;
        ST_WAIT_REQ1: state_code = `ESM_CODE_WAIT_REQ1;
        ST_WAIT_RST1: state_code = `ESM_CODE_WAIT_RST1;
        ST_ENABLE:    state_code = `ESM_CODE_ENABLE;
        ST_WAIT_REQ2: state_code = `ESM_CODE_WAIT_REQ2;
        ST_WAIT_RST2: state_code = `ESM_CODE_WAIT_RST2;
        ST_RST_ERR1:  state_code = `ESM_CODE_RST_ERR1;
        ST_RST_ERR2:  state_code = `ESM_CODE_RST_ERR2;
        default:      state_code = `ESM_CODE_IDLE;
      endcase
    end
  endfunction

  // true for the two reset error states
  function is_error;
    input [8:0] st;
    begin
      is_error = (st == ST_RST_ERR1) || (st == ST_RST_ERR2);
    end
  endfunction

  reg  [2:0]  ctrl_reg;
  reg  [2:0]  irq_stat_reg;
  reg  [2:0]  irq_stat_next;
  reg  [2:0]  irq_mask_reg;
  reg  [31:0] rdata_reg;
  reg  [31:0] rdata_next;
  reg  [8:0]  state_reg;
  reg  [8:0]  state_next;
  reg  [15:0] diag_reg;
  reg         ready_reg;
  reg         error_reg;
  reg         en_reg;
  reg         rst_prev_reg;
  reg         out_prev_reg;
  wire [1:0]  pins_s;
  wire        stop_ok;
  wire        rst_lvl;
  wire        rst_rise;
  wire        tick;
  wire        activate;
  wire        startup_auto;
  wire        release_auto;
  wire        enable_now;
  wire        ev_error;
  wire        ev_drop;
  wire        ev_raise;
  wire        stat_rd;

  // pin inputs cross into sys_clk
  esm_sync2 #(
    .W        (2)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in ({confirm_reset_in, stop_request_in}),
    .sync_out (pins_s)
  );

  // execution cycle enable
  esm_cycle_tick #(
    .DIV      (EXEC_DIV)
  ) u_tick (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .tick     (tick)
  );

  assign stop_ok      = pins_s[0];   // high: no demand
  assign rst_lvl      = pins_s[1];
  assign activate     = ctrl_reg[`ESM_CTRL_ACTIVATE];
  assign startup_auto = ctrl_reg[`ESM_CTRL_STARTUP];
  assign release_auto = ctrl_reg[`ESM_CTRL_RELEASE];

  // rising edge against the level seen last execution cycle
  assign rst_rise = rst_lvl & ~rst_prev_reg;

  // reset level held from the previous execution cycle
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_prev_reg <= 1'b0;
    end else if (tick) begin
      rst_prev_reg <= rst_lvl;
    end
  end

  // next state, evaluated once per execution cycle
  always @* begin
    state_next = state_reg;
    if (!activate) begin
      state_next = ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          state_next = ST_INIT;
        end
        ST_INIT: begin
          if (!startup_auto) begin
            state_next = ST_WAIT_REQ1;
          end else if (stop_ok) begin
            state_next = ST_ENABLE;
          end else begin
            state_next = ST_WAIT_REQ2;
          end
        end
        ST_WAIT_REQ1: begin
          if (stop_ok) begin
            if (rst_lvl) begin
              state_next = ST_RST_ERR1;
            end else begin
              state_next = ST_WAIT_RST1;
            end
          end
        end
        ST_WAIT_RST1: begin
          if (!stop_ok) begin
            state_next = ST_WAIT_REQ1;
          end else if (rst_rise) begin
            state_next = ST_ENABLE;
          end
        end
        ST_ENABLE: begin
          if (!stop_ok) begin
            state_next = ST_WAIT_REQ2;
          end
        end
        ST_WAIT_REQ2: begin
          if (stop_ok) begin
            if (release_auto) begin
              state_next = ST_ENABLE;
            end else if (rst_lvl) begin
              state_next = ST_RST_ERR2;
            end else begin
              state_next = ST_WAIT_RST2;
            end
          end
        end
        ST_WAIT_RST2: begin
          if (!stop_ok) begin
            state_next = ST_WAIT_REQ2;
          end else if (rst_rise) begin
            state_next = ST_ENABLE;
          end
        end
        ST_RST_ERR1: begin
          if (!rst_lvl) begin
            state_next = ST_WAIT_REQ1;
          end
        end
        ST_RST_ERR2: begin
          if (!rst_lvl) begin
            state_next = ST_WAIT_REQ2;
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  // state and registered outputs, all low in idle
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      diag_reg  <= `ESM_CODE_IDLE;
      ready_reg <= 1'b0;
      error_reg <= 1'b0;
      en_reg    <= 1'b0;
    end else if (tick) begin
      state_reg <= state_next;
      diag_reg  <= state_code(state_next);
      ready_reg <= (state_next != ST_IDLE);
      error_reg <= is_error(state_next);
      en_reg    <= (state_next == ST_ENABLE);
    end
  end

  // enable gated by the live request level, no cycle wait
  assign enable_now        = en_reg & stop_ok;
  assign safety_enable_out = enable_now;
  assign ready_out         = ready_reg;
  assign error_out         = error_reg;
  assign diagnostic_code   = diag_reg;

  // previous output level for edge events
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_prev_reg <= 1'b0;
    end else begin
      out_prev_reg <= enable_now;
    end
  end

  // interrupt events
  assign ev_error = tick & is_error(state_next) & ~is_error(state_reg);
  assign ev_drop  = out_prev_reg & ~enable_now;
  assign ev_raise = ~out_prev_reg & enable_now;
  assign stat_rd  = reg_rd & (reg_addr == `ESM_ADDR_IRQ_STAT);

  // sticky status: read clears, a new event wins
  always @* begin
    irq_stat_next = irq_stat_reg;
    if (stat_rd) begin
      irq_stat_next = `ESM_IRQ_RESET;
    end
    irq_stat_next[`ESM_IRQ_ERROR] = irq_stat_next[`ESM_IRQ_ERROR] | ev_error;
    irq_stat_next[`ESM_IRQ_DROP]  = irq_stat_next[`ESM_IRQ_DROP] | ev_drop;
    irq_stat_next[`ESM_IRQ_RAISE] = irq_stat_next[`ESM_IRQ_RAISE] | ev_raise;
  end

  // control, mask and interrupt status registers
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg     <= `ESM_CTRL_RESET;
      irq_mask_reg <= `ESM_IRQ_RESET;
      irq_stat_reg <= `ESM_IRQ_RESET;
    end else begin
      irq_stat_reg <= irq_stat_next;
      if (reg_wr && reg_addr == `ESM_ADDR_CTRL) begin
        ctrl_reg <= reg_wdata[2:0];
      end
      if (reg_wr && reg_addr == `ESM_ADDR_IRQ_MASK) begin
        irq_mask_reg <= reg_wdata[2:0];
      end
    end
  end

  assign irq_out = |(irq_stat_reg & irq_mask_reg);

  // read mux; unmapped offsets read zero
  always @* begin
    rdata_next = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        `ESM_ADDR_CTRL: begin
          rdata_next[2:0] = ctrl_reg;
        end
        `ESM_ADDR_STATUS: begin
          rdata_next[15:0]             = diag_reg;
          rdata_next[`ESM_STAT_READY]  = ready_reg;
          rdata_next[`ESM_STAT_ENABLE] = enable_now;
          rdata_next[`ESM_STAT_ERROR]  = error_reg;
          rdata_next[`ESM_STAT_STOP]   = stop_ok;
          rdata_next[`ESM_STAT_RESET]  = rst_lvl;
        end
        `ESM_ADDR_IRQ_STAT: begin
          rdata_next[2:0] = irq_stat_reg;
        end
        `ESM_ADDR_IRQ_MASK: begin
          rdata_next[2:0] = irq_mask_reg;
        end
        default: begin
          rdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  // read data stands one cycle after the strobe only
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

endmodule // esm_emergency_stop_monitor

/* File: esm_button.sv */
// emergency stop button model: one contact plus operator reset key
// assumes the bench commands press and key; lag slows the contact
`timescale 1ns/10ps
module esm_button (
  // clock
  input  wire       sys_clk,
  // commands from the bench
  input  wire       press,
  input  wire       key,
  input  wire [1:0] lag,
  // pins to the monitor
  output reg        stop_request_in,
  output reg        confirm_reset_in
);
  reg [1:0] cnt_reg;
  initial begin
    stop_request_in = 1'b1;
    confirm_reset_in = 1'b0;
    cnt_reg = 2'h0;
  end
  // contact opens on press, so low means demand
  always @(posedge sys_clk) begin
    cnt_reg <= 2'h0;
    if (stop_request_in == press) begin
      cnt_reg <= cnt_reg + 2'h1;
      if (cnt_reg >= lag) begin
        stop_request_in <= !press;
      end
    end
    // key gives the edge, dropping it clears errors
    confirm_reset_in <= key;
  end
endmodule // esm_button

/* File: esm_checker_assertions.sv */
// checker for the emergency stop monitor; sees only the top ports
// assumes EXEC_DIV of at most 4
`timescale 1ns/10ps
module esm_checker #(
  parameter EXEC_DIV = 125
) (
  // clock and reset
  input wire        sys_clk,
  input wire        rst_n,
  // register port
  input wire [7:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  // pins and outputs
  input wire        stop_request_in,
  input wire        confirm_reset_in,
  input wire        safety_enable_out,
  input wire        ready_out,
  input wire        error_out,
  input wire [15:0] diagnostic_code,
  input wire        irq_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  stop_drop_a: assert property (
    !stop_request_in [*4] |-> !safety_enable_out)
    else $error("enable high under stop demand");
  demand_hold_a: assert property (
    !stop_request_in [*8] |-> !(diagnostic_code inside
      {16'h8000, 16'h8003, 16'h8005}))
    else $error("enable or reset wait under demand");
  enable_state_a: assert property (
    safety_enable_out |-> diagnostic_code == 16'h8000 && !error_out)
    else $error("enable outside enabled state");
  err_match_a: assert property (
    error_out == (diagnostic_code inside {16'hc001, 16'hc002}))
    else $error("error flag does not match state");
  err_outputs_a: assert property (
    error_out |-> ready_out && !safety_enable_out)
    else $error("error state outputs wrong");
  ready_idle_a: assert property (
    ready_out == (diagnostic_code != 16'h0000))
    else $error("ready does not match idle");
  wait_rst_a: assert property (
    diagnostic_code == 16'h8003 |-> ready_out && !safety_enable_out)
    else $error("reset wait outputs wrong");
  deact_idle_a: assert property (
    reg_wr && reg_addr == 8'h00 && !reg_wdata[0]
      |-> ##[1:8] diagnostic_code == 16'h0000)
    else $error("deactivation did not reach idle");
  code_set_a: assert property (
    diagnostic_code inside {16'h0000, 16'h8001, 16'h8002, 16'h8003,
      16'h8000, 16'h8004, 16'h8005, 16'hc001, 16'hc002})
    else $error("unknown state code");
  status_rd_a: assert property (
    reg_rd && reg_addr == 8'h04
      |=> reg_rdata[15:0] == $past(diagnostic_code))
    else $error("status read lost state code");
endmodule // esm_checker
bind esm_emergency_stop_monitor esm_checker #(.EXEC_DIV(EXEC_DIV)) chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .stop_request_in(stop_request_in),
  .confirm_reset_in(confirm_reset_in),
  .safety_enable_out(safety_enable_out), .ready_out(ready_out),
  .error_out(error_out), .diagnostic_code(diagnostic_code),
  .irq_out(irq_out));

/* File: esm_emergency_stop_monitor_tb.sv */
// self-checking bench for the emergency stop monitor
// assumes the button model on the pins and EXEC_DIV shortened to 2
`timescale 1ns/10ps
module esm_emergency_stop_monitor_tb;
  reg         sys_clk;
  reg         rst_n;
  reg  [7:0]  reg_addr;
  reg  [31:0] reg_wdata;
  reg         reg_wr;
  reg         reg_rd;
  wire [31:0] reg_rdata;
  wire        stop_request_in;
  wire        confirm_reset_in;
  wire        safety_enable_out;
  wire        ready_out;
  wire        error_out;
  wire [15:0] diagnostic_code;
  wire        irq_out;
  reg         press;
  reg         key;
  reg  [1:0]  lag;
  reg  [31:0] m;
  int         num_errors;
  int         comparisons;
  int         seed;

  // device and its button
  esm_emergency_stop_monitor #(.EXEC_DIV(2)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .stop_request_in(stop_request_in),
    .confirm_reset_in(confirm_reset_in),
    .safety_enable_out(safety_enable_out), .ready_out(ready_out),
    .error_out(error_out), .diagnostic_code(diagnostic_code),
    .irq_out(irq_out));
  esm_button btn (
    .sys_clk(sys_clk), .press(press), .key(key), .lag(lag),
    .stop_request_in(stop_request_in),
    .confirm_reset_in(confirm_reset_in));

  // expected interrupt line from mask and status
  function automatic logic exp_irq(input [31:0] mk, input [31:0] st);
    return |(mk & st & 32'h7);
  endfunction

  task chk(input string nm, input [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task wr(input [7:0] a, input [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task rdc(input string nm, input [7:0] a, input [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(nm, e, reg_rdata);
  endtask

  task wait_code(input [15:0] c);
    #1;
    for (int i = 0; i < 64 && diagnostic_code !== c; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk("diagnostic_code", {16'h0, c}, {16'h0, diagnostic_code});
    // a state that never came is a hang: report and stop here
    if (diagnostic_code !== c) begin
      wrap_up;
    end
  endtask

  task pulse_key;
    key <= 1'b1;
    repeat (8) @(posedge sys_clk);
    key <= 1'b0;
    // let the low key level pass the pin and the synchroniser
    repeat (4) @(posedge sys_clk);
  endtask

  task wrap_up;
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    press = 1'b0;
    key = 1'b0;
    lag = 2'h0;
    seed = $urandom(92);
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1 chk("outputs", 0, {diagnostic_code, ready_out, safety_enable_out,
      error_out});
    wr(8'h0c, 32'h7);
    rdc("unmapped", 8'h10, 32'h0);
    wr(8'h00, 32'h1);
    wait_code(16'h8003);
    chk("enable", 0, safety_enable_out);
    pulse_key;
    wait_code(16'h8000);
    chk("enable", 1, safety_enable_out);
    rdc("status", 8'h04, 32'h000b8000);
    chk("irq", 1, irq_out);
    rdc("irq_stat", 8'h08, 32'h4);
    chk("irq", 0, irq_out);
    press <= 1'b1;
    repeat (5) @(posedge sys_clk);
    #1 chk("enable", 0, safety_enable_out);
    wait_code(16'h8004);
    press <= 1'b0;
    wait_code(16'h8005);
    pulse_key;
    wait_code(16'h8000);
    press <= 1'b1;
    wait_code(16'h8004);
    key <= 1'b1;
    press <= 1'b0;
    wait_code(16'hc002);
    chk("err", 3'h5, {ready_out, safety_enable_out, error_out});
    key <= 1'b0;
    wait_code(16'h8005);
    chk("err", 0, error_out);
    pulse_key;
    wait_code(16'h8000);
    wr(8'h00, 32'h0);
    wait_code(16'h0000);
    key <= 1'b1;
    wr(8'h00, 32'h1);
    wait_code(16'hc001);
    wr(8'h00, 32'h0);
    wait_code(16'h0000);
    key <= 1'b0;
    press <= 1'b1;
    wr(8'h00, 32'h3);
    wait_code(16'h8004);
    press <= 1'b0;
    wait_code(16'h8005);
    wr(8'h00, 32'h0);
    wait_code(16'h0000);
    wr(8'h00, 32'h7);
    wait_code(16'h8000);
    rdc("irq_stat", 8'h08, 32'h7);
    // random presses with self release and random masks
    repeat (12) begin
      m = $urandom;
      lag <= 2'($urandom);
      wr(8'h0c, m);
      rdc("mask", 8'h0c, m & 32'h7);
      press <= 1'b1;
      repeat ($urandom_range(20, 1)) @(posedge sys_clk);
      wait_code(16'h8004);
      press <= 1'b0;
      wait_code(16'h8000);
      // the raise event lands in status one clock after the state
      @(posedge sys_clk);
      #1 chk("irq", exp_irq(m, 32'h6), irq_out);
      rdc("irq_stat", 8'h08, 32'h6);
    end
    wrap_up;
  end
endmodule // esm_emergency_stop_monitor_tb
